// ---- common/stgvm_pkg.sv ----
// Purpose: constants for stop gating and address map decode
// Assumes: 16-bit address space, 8-bit data
// Notes:   vector addresses are the high byte of each pair
package stgvm_pkg;
    localparam logic [15:0] DP_LO      = 16'h0000;
    localparam logic [15:0] DP_HI      = 16'h007f;
    localparam logic [15:0] HP_LO      = 16'h1800;
    localparam logic [15:0] HP_HI      = 16'h185f;
    localparam logic [15:0] NV_LO      = 16'hffb0;
    localparam logic [15:0] NV_HI      = 16'hffbf;
    localparam logic [15:0] NV_KEY_LO  = 16'hffb0;
    localparam logic [15:0] NV_KEY_HI  = 16'hffb7;
    localparam logic [15:0] NV_PROT_AD = 16'hffbd;
    localparam logic [15:0] NV_OPT_AD  = 16'hffbf;
    localparam logic [7:0]  ZERO_BYTE  = 8'h00;
    localparam logic [7:0]  RESET_BYTE = 8'h00;

    // vector index: code presented by the core, one per source
    localparam int          VEC_N      = 21;
    localparam logic [4:0]  VI_RESET   = 5'h00;
    localparam logic [4:0]  VI_SWI     = 5'h01;
    localparam logic [4:0]  VI_IRQ     = 5'h02;
    localparam logic [4:0]  VI_LVD     = 5'h03;
    localparam logic [4:0]  VI_T1CH0   = 5'h04;
    localparam logic [4:0]  VI_T1CH1   = 5'h05;
    localparam logic [4:0]  VI_T1OVF   = 5'h06;
    localparam logic [4:0]  VI_T2CH0   = 5'h07;
    localparam logic [4:0]  VI_T2CH1   = 5'h08;
    localparam logic [4:0]  VI_T2OVF   = 5'h09;
    localparam logic [4:0]  VI_SPI     = 5'h0a;
    localparam logic [4:0]  VI_SERR    = 5'h0b;
    localparam logic [4:0]  VI_SRX     = 5'h0c;
    localparam logic [4:0]  VI_STX     = 5'h0d;
    localparam logic [4:0]  VI_PORTA   = 5'h0e;
    localparam logic [4:0]  VI_PORTB   = 5'h0f;
    localparam logic [4:0]  VI_ADC     = 5'h10;
    localparam logic [4:0]  VI_I2C     = 5'h11;
    localparam logic [4:0]  VI_RTC     = 5'h12;
    localparam logic [4:0]  VI_MODULO_TIMER    = 5'h13;
    localparam logic [4:0]  VI_ANALOG_COMPARATOR    = 5'h14;

    localparam logic [15:0] VA_RESET   = 16'hfffe;
    localparam logic [15:0] VA_SWI     = 16'hfffc;
    localparam logic [15:0] VA_IRQ     = 16'hfffa;
    localparam logic [15:0] VA_LVD     = 16'hfff8;
    localparam logic [15:0] VA_T1CH0   = 16'hfff4;
    localparam logic [15:0] VA_T1CH1   = 16'hfff2;
    localparam logic [15:0] VA_T1OVF   = 16'hffe8;
    localparam logic [15:0] VA_T2CH0   = 16'hffe6;
    localparam logic [15:0] VA_T2CH1   = 16'hffe4;
    localparam logic [15:0] VA_T2OVF   = 16'hffe2;
    localparam logic [15:0] VA_SPI     = 16'hffe0;
    localparam logic [15:0] VA_SERR    = 16'hffde;
    localparam logic [15:0] VA_SRX     = 16'hffdc;
    localparam logic [15:0] VA_STX     = 16'hffda;
    localparam logic [15:0] VA_PORTA   = 16'hffd6;
    localparam logic [15:0] VA_PORTB   = 16'hffd4;
    localparam logic [15:0] VA_ADC     = 16'hffd0;
    localparam logic [15:0] VA_I2C     = 16'hffce;
    localparam logic [15:0] VA_RTC     = 16'hffcc;
    localparam logic [15:0] VA_MODULO_TIMER    = 16'hffca;
    localparam logic [15:0] VA_ANALOG_COMPARATOR    = 16'hffc2;
    localparam logic [15:0] VA_LOW_OFS = 16'h0001;

    typedef enum logic [1:0] {STGVM_RUN, STGVM_STOP2, STGVM_STOP3} stgvm_mode_e;
endpackage

// ---- hw/stgvm_top.sv ----
// Purpose: stop-mode clock/power gating, address decode and vector map
// Assumes: core pulses stop_req_i once per stop instruction; wake_i ends stop
// Notes:   power enables are high for on; standby outputs are high for standby
`timescale 1ns/1ps
module stgvm_top
(
    input  wire logic        clk_i,
    input  wire logic        nrst_i,
    input  wire logic        stop_req_i,
    input  wire logic        wake_i,
    input  wire logic        debug_entry_enable_i,
    input  wire logic        lowvolt_stop_enable_i,
    input  wire logic        lvd_enable_i,
    input  wire logic        adc_async_clk_i,
    input  wire logic        analog_comparator_bandgap_i,
    input  wire logic        int_ref_clk_enable_i,
    input  wire logic        int_ref_stop_enable_i,
    input  wire logic        ext_ref_clk_enable_i,
    input  wire logic        ext_ref_stop_enable_i,
    input  wire logic        osc_high_range_i,
    input  wire logic        rtc_enable_i,
    input  wire logic [15:0] addr_i,
    input  wire logic        direct_i,
    input  wire logic        wr_i,
    input  wire logic [7:0]  bit_mask_i,
    input  wire logic [1:0]  bit_op_i,
    input  wire logic [7:0]  reg_rdata_i,
    input  wire logic [7:0]  reg_fixed_zero_i,
    input  wire logic [4:0]  vec_sel_i,
    input  wire logic        vec_low_i,
    input  wire logic [7:0]  nv_prot_flash_i,
    input  wire logic [7:0]  nv_opt_flash_i,
    input  wire logic        flash_prog_i,
    output logic             periph_clk_en_o,
    output logic             debug_clk_en_o,
    output logic             mode_stop2_o,
    output logic             mode_stop3_o,
    output logic             core_off_o,
    output logic             core_standby_o,
    output logic             ram_standby_o,
    output logic             adc_on_o,
    output logic             analog_comparator_on_o,
    output logic             ics_on_o,
    output logic             osc_on_o,
    output logic             reg_full_o,
    output logic             lvd_on_o,
    output logic             rtc_on_o,
    output logic             pins_hold_o,
    output logic             sel_direct_o,
    output logic             sel_high_o,
    output logic             sel_nv_o,
    output logic             sel_key_o,
    output logic             nv_wr_blocked_o,
    output logic [15:0]      eff_addr_o,
    output logic [7:0]       bit_wdata_o,
    output logic             bit_test_o,
    output logic [7:0]       rdata_o,
    output logic [15:0]      vec_addr_o,
    output logic [7:0]       nv_protection_byte_o,
    output logic [7:0]       nv_option_byte_o
);
    stgvm_pkg::stgvm_mode_e mode;
    stgvm_pkg::stgvm_mode_e next_mode;
    logic                   dbg_at_entry;
    logic                   lvd_at_entry;
    logic                   nv_loaded;
    logic [15:0]            ea;

    default clocking cb_chk @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    function automatic logic [15:0] vec_base(input logic [4:0] sel);
        unique case (sel)
            stgvm_pkg::VI_RESET: vec_base = stgvm_pkg::VA_RESET;
            stgvm_pkg::VI_SWI:   vec_base = stgvm_pkg::VA_SWI;
            stgvm_pkg::VI_IRQ:   vec_base = stgvm_pkg::VA_IRQ;
            stgvm_pkg::VI_LVD:   vec_base = stgvm_pkg::VA_LVD;
            stgvm_pkg::VI_T1CH0: vec_base = stgvm_pkg::VA_T1CH0;
            stgvm_pkg::VI_T1CH1: vec_base = stgvm_pkg::VA_T1CH1;
            stgvm_pkg::VI_T1OVF: vec_base = stgvm_pkg::VA_T1OVF;
            stgvm_pkg::VI_T2CH0: vec_base = stgvm_pkg::VA_T2CH0;
            stgvm_pkg::VI_T2CH1: vec_base = stgvm_pkg::VA_T2CH1;
            stgvm_pkg::VI_T2OVF: vec_base = stgvm_pkg::VA_T2OVF;
            stgvm_pkg::VI_SPI:   vec_base = stgvm_pkg::VA_SPI;
            stgvm_pkg::VI_SERR:  vec_base = stgvm_pkg::VA_SERR;
            stgvm_pkg::VI_SRX:   vec_base = stgvm_pkg::VA_SRX;
            stgvm_pkg::VI_STX:   vec_base = stgvm_pkg::VA_STX;
            stgvm_pkg::VI_PORTA: vec_base = stgvm_pkg::VA_PORTA;
            stgvm_pkg::VI_PORTB: vec_base = stgvm_pkg::VA_PORTB;
            stgvm_pkg::VI_ADC:   vec_base = stgvm_pkg::VA_ADC;
            stgvm_pkg::VI_I2C:   vec_base = stgvm_pkg::VA_I2C;
            stgvm_pkg::VI_RTC:   vec_base = stgvm_pkg::VA_RTC;
            stgvm_pkg::VI_MODULO_TIMER:  vec_base = stgvm_pkg::VA_MODULO_TIMER;
            stgvm_pkg::VI_ANALOG_COMPARATOR:  vec_base = stgvm_pkg::VA_ANALOG_COMPARATOR;
            // unused codes fall back to the reset slot
            default:             vec_base = stgvm_pkg::VA_RESET;
        endcase
    endfunction

    function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
                                      input logic [15:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction

    // stop selection; fallback decided from levels at the request
    always_comb
    begin
        next_mode = mode;
        unique case (mode)
            stgvm_pkg::STGVM_RUN:
            begin
                if (stop_req_i)
                begin
                    if (debug_entry_enable_i || lowvolt_stop_enable_i)
                        next_mode = stgvm_pkg::STGVM_STOP3;
                    else
                        next_mode = stgvm_pkg::STGVM_STOP2;
                end
            end
            stgvm_pkg::STGVM_STOP2,
            stgvm_pkg::STGVM_STOP3:
            begin
                if (wake_i)
                    next_mode = stgvm_pkg::STGVM_RUN;
            end
            default: next_mode = stgvm_pkg::STGVM_RUN;
        endcase
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            mode <= stgvm_pkg::STGVM_RUN;
        else
            mode <= next_mode;
    end

    // conditions captured at stop entry
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            dbg_at_entry <= 1'b0;
            lvd_at_entry <= 1'b0;
        end
        else if (mode == stgvm_pkg::STGVM_RUN && stop_req_i)
        begin
            dbg_at_entry <= debug_entry_enable_i;
            lvd_at_entry <= lvd_enable_i && lowvolt_stop_enable_i;
        end
    end

    logic s2;
    logic s3;
    assign s2 = (mode == stgvm_pkg::STGVM_STOP2);
    assign s3 = (mode == stgvm_pkg::STGVM_STOP3);

    assign mode_stop2_o    = s2;
    assign mode_stop3_o    = s3;
    assign periph_clk_en_o = !(s2 || s3);
    assign debug_clk_en_o  = !s2 && (!s3 || dbg_at_entry);
    assign core_off_o      = s2;
    assign core_standby_o  = s3;
    assign ram_standby_o   = s2 || s3;
    assign pins_hold_o     = s2 || s3;
    assign rtc_on_o        = rtc_enable_i;
    assign lvd_on_o        = !s2 && (!s3 || lvd_at_entry);
    assign adc_on_o        = !s2 && (!s3 || (adc_async_clk_i && lvd_at_entry));
    assign analog_comparator_on_o       = !s2 && (!s3 || !analog_comparator_bandgap_i || lvd_at_entry);
    assign ics_on_o        = !s2 &&
                             (!s3 || (int_ref_clk_enable_i && int_ref_stop_enable_i));
    assign osc_on_o        = !s2 && (!s3 || (ext_ref_clk_enable_i && ext_ref_stop_enable_i
                             && (!osc_high_range_i || lvd_at_entry)));
    assign reg_full_o      = !s2 && (!s3 || dbg_at_entry || lvd_at_entry);

    // address decode
    assign ea = direct_i ? {stgvm_pkg::ZERO_BYTE, addr_i[7:0]} : addr_i;
    assign eff_addr_o      = ea;
    assign sel_direct_o    = in_range(ea, stgvm_pkg::DP_LO, stgvm_pkg::DP_HI);
    assign sel_high_o      = in_range(ea, stgvm_pkg::HP_LO, stgvm_pkg::HP_HI);
    assign sel_nv_o        = in_range(ea, stgvm_pkg::NV_LO, stgvm_pkg::NV_HI);
    assign sel_key_o       = in_range(ea, stgvm_pkg::NV_KEY_LO, stgvm_pkg::NV_KEY_HI);
    assign nv_wr_blocked_o = sel_nv_o && wr_i && !flash_prog_i;

    // read-modify-write for bit set/clear/test on direct page
    always_comb
    begin
        bit_wdata_o = reg_rdata_i & ~reg_fixed_zero_i;
        bit_test_o  = 1'b0;
        if (sel_direct_o)
        begin
            unique case (bit_op_i)
                2'h1: bit_wdata_o = (reg_rdata_i | bit_mask_i) & ~reg_fixed_zero_i;
                2'h2: bit_wdata_o = (reg_rdata_i & ~bit_mask_i) & ~reg_fixed_zero_i;
                2'h3: bit_test_o  = |(reg_rdata_i & bit_mask_i & ~reg_fixed_zero_i);
                default: bit_wdata_o = reg_rdata_i & ~reg_fixed_zero_i;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            rdata_o <= stgvm_pkg::RESET_BYTE;
        else
            rdata_o <= reg_rdata_i & ~reg_fixed_zero_i;
    end

    // vector fetch: high byte address, then low byte address
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            vec_addr_o <= stgvm_pkg::VA_RESET;
        else if (vec_low_i)
            vec_addr_o <= vec_base(vec_sel_i) + stgvm_pkg::VA_LOW_OFS;
        else
            vec_addr_o <= vec_base(vec_sel_i);
    end

    // protection and option bytes load once after reset release
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            nv_loaded            <= 1'b0;
            nv_protection_byte_o <= stgvm_pkg::RESET_BYTE;
            nv_option_byte_o     <= stgvm_pkg::RESET_BYTE;
        end
        else if (!nv_loaded)
        begin
            nv_loaded            <= 1'b1;
            nv_protection_byte_o <= nv_prot_flash_i;
            nv_option_byte_o     <= nv_opt_flash_i;
        end
    end

    // stop-mode power checks
    AST_CLK_HALT: assert property
        ((s2 || s3) |-> !periph_clk_en_o)
        else $error("peripheral clock running in stop");
    AST_DBG_CLK: assert property
        ((mode == stgvm_pkg::STGVM_RUN && stop_req_i && debug_entry_enable_i)
        |=> debug_clk_en_o && !periph_clk_en_o)
        else $error("debug clock lost in stop");
    AST_DBG_FALLBACK: assert property
        ((mode == stgvm_pkg::STGVM_RUN && stop_req_i && debug_entry_enable_i)
        |=> mode_stop3_o)
        else $error("debug enable did not force stop3");
    AST_LV_FALLBACK: assert property
        ((mode == stgvm_pkg::STGVM_RUN && stop_req_i && lowvolt_stop_enable_i)
        |=> mode_stop3_o)
        else $error("low-voltage stop enable did not force stop3");
    AST_STOP2_OFF: assert property
        (mode_stop2_o |-> core_off_o && !reg_full_o && !osc_on_o && pins_hold_o)
        else $error("stop2 power state wrong");
    AST_STOP2_UNITS: assert property
        (mode_stop2_o |-> !adc_on_o && !analog_comparator_on_o && !ics_on_o && !lvd_on_o)
        else $error("unit left on in stop2");
    AST_STOP3_STANDBY: assert property
        (mode_stop3_o |-> core_standby_o && !core_off_o && ram_standby_o && pins_hold_o)
        else $error("stop3 standby state wrong");
    AST_REG_FULL: assert property
        (mode_stop3_o |-> (reg_full_o == (dbg_at_entry || lvd_at_entry)))
        else $error("regulator state wrong in stop3");
    AST_REG_ENTRY: assert property
        ((mode == stgvm_pkg::STGVM_RUN && stop_req_i) |=> reg_full_o == (mode_stop3_o &&
        ($past(debug_entry_enable_i) || ($past(lvd_enable_i) && $past(lowvolt_stop_enable_i)))))
        else $error("regulator state wrong after stop entry");
    AST_ADC_STOP3: assert property
        ((mode_stop3_o && !(adc_async_clk_i && lvd_at_entry)) |-> !adc_on_o)
        else $error("converter on in stop3 without its conditions");
    AST_ANALOG_COMPARATOR_STOP3: assert property
        ((mode_stop3_o && analog_comparator_bandgap_i && !lvd_at_entry) |-> !analog_comparator_on_o)
        else $error("comparator on bandgap without detector");
    AST_ICS_STOP3: assert property
        (mode_stop3_o |-> ics_on_o == (int_ref_clk_enable_i && int_ref_stop_enable_i))
        else $error("clock source state wrong in stop3");
    AST_OSC_STOP3: assert property
        ((mode_stop3_o && !(ext_ref_clk_enable_i && ext_ref_stop_enable_i)) |-> !osc_on_o)
        else $error("oscillator on in stop3 without enables");
    AST_OSC_HIGH: assert property
        ((mode_stop3_o && osc_high_range_i && !lvd_at_entry) |-> !osc_on_o)
        else $error("high range oscillator on without detector");

    // address and vector checks
    AST_DIRECT: assert property
        (direct_i |-> sel_direct_o == !addr_i[7])
        else $error("direct page decode wrong");
    AST_DIRECT_ZERO: assert property
        (direct_i |-> eff_addr_o[15:8] == stgvm_pkg::ZERO_BYTE)
        else $error("direct address high byte not zero");
    AST_HIGH_PAGE: assert property
        ((!direct_i && addr_i >= stgvm_pkg::HP_LO && addr_i <= stgvm_pkg::HP_HI)
        |-> sel_high_o && !sel_direct_o && !sel_nv_o)
        else $error("high page decode wrong");
    AST_KEY_IN_NV: assert property
        (sel_key_o |-> sel_nv_o)
        else $error("key area outside nonvolatile area");
    AST_NV_WR: assert property
        ((wr_i && !flash_prog_i && !direct_i && addr_i >= stgvm_pkg::NV_LO
        && addr_i <= stgvm_pkg::NV_HI) |-> nv_wr_blocked_o)
        else $error("ordinary write to nonvolatile area not blocked");
    AST_VEC_RESET: assert property
        ((vec_sel_i == stgvm_pkg::VI_RESET && !vec_low_i) |=> vec_addr_o == stgvm_pkg::VA_RESET)
        else $error("reset vector address wrong");
    AST_VEC_PAIR: assert property
        (nrst_i |=> vec_addr_o[0] == $past(vec_low_i))
        else $error("vector byte of pair wrong");
    AST_VEC_PERIPH: assert property
        ((vec_sel_i == stgvm_pkg::VI_SPI && !vec_low_i) |=> vec_addr_o == stgvm_pkg::VA_SPI)
        else $error("peripheral vector address wrong");
    AST_BIT_SET: assert property
        ((sel_direct_o && bit_op_i == 2'h1)
        |-> (bit_wdata_o & bit_mask_i) == (bit_mask_i & ~reg_fixed_zero_i))
        else $error("bit set lost");
    AST_NV_LOAD: assert property
        ((nrst_i && !nv_loaded) |=> nv_option_byte_o == $past(nv_opt_flash_i)
        && nv_protection_byte_o == $past(nv_prot_flash_i))
        else $error("protection or option byte not copied");
    AST_ZERO_BITS: assert property
        (##1 (rdata_o & $past(reg_fixed_zero_i)) == stgvm_pkg::ZERO_BYTE)
        else $error("fixed-zero bit read as one");

    COV_STOP2: cover property
        (mode_stop2_o ##1 wake_i ##1 !mode_stop2_o);
    COV_STOP3_DBG: cover property
        (mode_stop3_o && dbg_at_entry);
    COV_STOP3_LV: cover property
        (mode_stop3_o && lvd_at_entry);
    COV_VEC_PAIR: cover property
        (!vec_low_i ##1 vec_low_i);
    COV_NV_BLOCK: cover property
        (nv_wr_blocked_o ##1 !nv_wr_blocked_o);
endmodule

// ---- dv/stgvm_periph_model.sv ----
// Purpose: peripheral register and flash side of the stop/map block
// Assumes: register contents depend only on the decoded address
// Notes:   alt_i stands for a flash reprogram of the nonvolatile area
`timescale 1ns/1ps
module stgvm_periph_model
#(
    parameter logic [7:0] PROT = 8'h3c,
    parameter logic [7:0] OPT  = 8'h81
)
(
    input  wire logic [15:0] addr_i,
    input  wire logic        alt_i,
    output logic [7:0]       rdata_o,
    output logic [7:0]       fixed_zero_o,
    output logic [7:0]       prot_o,
    output logic [7:0]       opt_o
);
    // mixed ones and zeros so bit operations show both directions
    assign rdata_o      = addr_i[7:0] ^ 8'ha5;
    // first port data register has its two top bits fixed at zero
    assign fixed_zero_o = (addr_i == 16'h0000) ? 8'hc0 : 8'h00;
    assign prot_o       = alt_i ? ~PROT : PROT;
    assign opt_o        = alt_i ? ~OPT : OPT;
endmodule

// ---- dv/stgvm_top_test.sv ----
// Purpose: bench for stop gating, address decode and vector map
// Assumes: inputs change by non-blocking assignment on the rising edge
// Notes:   one task per scenario
`timescale 1ns/1ps
module stgvm_top_test;
    localparam logic [7:0] PROT = 8'h3c;
    localparam logic [7:0] OPT  = 8'h81;
    logic        clk_i, nrst_i, stop_req_i, wake_i, debug_entry_enable_i, lowvolt_stop_enable_i;
    logic        lvd_enable_i, adc_async_clk_i, analog_comparator_bandgap_i, int_ref_clk_enable_i;
    logic        int_ref_stop_enable_i, ext_ref_clk_enable_i, ext_ref_stop_enable_i;
    logic        osc_high_range_i, rtc_enable_i, direct_i, wr_i, vec_low_i, flash_prog_i;
    logic        periph_clk_en_o, debug_clk_en_o, mode_stop2_o, mode_stop3_o, core_off_o;
    logic        core_standby_o, ram_standby_o, adc_on_o, analog_comparator_on_o, ics_on_o, osc_on_o;
    logic        reg_full_o, lvd_on_o, rtc_on_o, pins_hold_o, sel_direct_o, sel_high_o;
    logic        sel_nv_o, sel_key_o, nv_wr_blocked_o, bit_test_o, flash_alt;
    logic [1:0]  bit_op_i;
    logic [4:0]  vec_sel_i;
    logic [7:0]  bit_mask_i, reg_rdata_i, reg_fixed_zero_i, nv_prot_flash_i, nv_opt_flash_i;
    logic [7:0]  bit_wdata_o, rdata_o, nv_protection_byte_o, nv_option_byte_o;
    logic [15:0] addr_i, eff_addr_o, vec_addr_o;
    logic [15:0] vtab [22] = '{16'hfffe, 16'hfffc, 16'hfffa, 16'hfff8, 16'hfff4, 16'hfff2,
        16'hffe8, 16'hffe6, 16'hffe4, 16'hffe2, 16'hffe0, 16'hffde, 16'hffdc, 16'hffda,
        16'hffd6, 16'hffd4, 16'hffd0, 16'hffce, 16'hffcc, 16'hffca, 16'hffc2, 16'hfffe};
    logic [15:0] atab [14] = '{16'h0000, 16'h007f, 16'h0080, 16'h17ff, 16'h1800, 16'h185f,
        16'h1860, 16'hffaf, 16'hffb0, 16'hffb7, 16'hffb8, 16'hffbf, 16'hffc2, 16'hab04};
    logic [3:0]  stab [14] = '{4'h8, 4'h8, 4'h0, 4'h0, 4'h4, 4'h4, 4'h0, 4'h0, 4'h3, 4'h3,
        4'h2, 4'h2, 4'h0, 4'h8};
    logic [9:0]  ctab [6] = '{10'h000, 10'h21f, 10'h1ff, 10'h177, 10'h10e, 10'h0be};
    int          bad_count = 0;
    int          checks_done = 0;

    stgvm_top u_dut
    (
        .clk_i, .nrst_i, .stop_req_i, .wake_i, .debug_entry_enable_i, .lowvolt_stop_enable_i,
        .lvd_enable_i, .adc_async_clk_i, .analog_comparator_bandgap_i, .int_ref_clk_enable_i,
        .int_ref_stop_enable_i, .ext_ref_clk_enable_i, .ext_ref_stop_enable_i,
        .osc_high_range_i, .rtc_enable_i, .addr_i, .direct_i, .wr_i, .bit_mask_i, .bit_op_i,
        .reg_rdata_i, .reg_fixed_zero_i, .vec_sel_i, .vec_low_i, .nv_prot_flash_i,
        .nv_opt_flash_i, .flash_prog_i, .periph_clk_en_o, .debug_clk_en_o, .mode_stop2_o,
        .mode_stop3_o, .core_off_o, .core_standby_o, .ram_standby_o, .adc_on_o, .analog_comparator_on_o,
        .ics_on_o, .osc_on_o, .reg_full_o, .lvd_on_o, .rtc_on_o, .pins_hold_o, .sel_direct_o,
        .sel_high_o, .sel_nv_o, .sel_key_o, .nv_wr_blocked_o, .eff_addr_o, .bit_wdata_o,
        .bit_test_o, .rdata_o, .vec_addr_o, .nv_protection_byte_o, .nv_option_byte_o
    );

    stgvm_periph_model #(.PROT(PROT), .OPT(OPT)) u_periph
    (
        .addr_i(eff_addr_o), .alt_i(flash_alt), .rdata_o(reg_rdata_i),
        .fixed_zero_o(reg_fixed_zero_i), .prot_o(nv_prot_flash_i), .opt_o(nv_opt_flash_i)
    );

    initial
    begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    // about 190 cycles are needed; a hang is cut off well above that
    initial
    begin
        repeat (3000) @(posedge clk_i);
        bad_count = bad_count + 1;
        end_of_test();
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done = checks_done + 1;
        if (seen !== exp)
        begin
            bad_count = bad_count + 1;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // cfg bits: debug, lv stop, lv enable, async clk, bandgap, int clk/stop, ext clk/stop, high
    task automatic stop_case(input logic [9:0] c);
        logic s3;
        logic lv;
        s3 = c[9] | c[8];
        lv = c[8] & c[7];
        @(posedge clk_i);
        {debug_entry_enable_i, lowvolt_stop_enable_i, lvd_enable_i, adc_async_clk_i,
         analog_comparator_bandgap_i, int_ref_clk_enable_i, int_ref_stop_enable_i, ext_ref_clk_enable_i,
         ext_ref_stop_enable_i, osc_high_range_i} <= c;
        rtc_enable_i <= c[7];
        stop_req_i   <= 1'b1;
        @(posedge clk_i);
        stop_req_i <= 1'b0;
        #1;
        chk({periph_clk_en_o, debug_clk_en_o}, {1'b0, c[9]});
        chk({mode_stop2_o, mode_stop3_o}, {!s3, s3});
        chk({core_off_o, core_standby_o, ram_standby_o, pins_hold_o}, {!s3, s3, 2'b11});
        chk({rtc_on_o, lvd_on_o}, {c[7], s3 & lv});
        chk(adc_on_o, s3 & c[6] & lv);
        chk(analog_comparator_on_o, s3 & (!c[5] | lv));
        chk(ics_on_o, s3 & c[4] & c[3]);
        chk(osc_on_o, s3 & c[2] & c[1] & (!c[0] | lv));
        chk(reg_full_o, s3 & (c[9] | lv));
        @(posedge clk_i);
        stop_req_i <= 1'b1;
        @(posedge clk_i);
        stop_req_i <= 1'b0;
        #1;
        chk({mode_stop2_o, mode_stop3_o, periph_clk_en_o}, {!s3, s3, 1'b0});
        @(posedge clk_i);
        wake_i <= 1'b1;
        @(posedge clk_i);
        wake_i <= 1'b0;
        #1;
        chk({mode_stop2_o, mode_stop3_o, periph_clk_en_o}, 3'b001);
        $display("stop test done");
    endtask

    task automatic decode();
        logic [7:0] exp;
        for (int i = 0; i < 14; i++)
        begin
            @(posedge clk_i);
            addr_i   <= atab[i];
            direct_i <= (i == 13);
            #1;
            chk(eff_addr_o, (i == 13) ? 16'h0004 : atab[i]);
            chk({sel_direct_o, sel_high_o, sel_nv_o, sel_key_o}, stab[i]);
            exp = reg_rdata_i & ~reg_fixed_zero_i;
            @(posedge clk_i);
            #1;
            chk(rdata_o, exp);
        end
        $display("decode test done");
    endtask

    task automatic bit_ops();
        logic [7:0] m;
        @(posedge clk_i);
        addr_i   <= 16'h0030;
        direct_i <= 1'b0;
        for (int i = 0; i < 24; i++)
        begin
            m = 8'h01 << (i % 8);
            @(posedge clk_i);
            bit_mask_i <= m;
            bit_op_i   <= 2'(i / 8 + 1);
            #1;
            if (i < 8)
                chk(bit_wdata_o, reg_rdata_i | m);
            else if (i < 16)
                chk(bit_wdata_o, reg_rdata_i & ~m);
            else
                chk(bit_test_o, |(reg_rdata_i & m));
        end
        @(posedge clk_i);
        bit_op_i <= 2'h0;
        $display("bit test done");
    endtask

    task automatic vectors();
        for (int i = 0; i < 44; i++)
        begin
            @(posedge clk_i);
            vec_sel_i <= 5'(i / 2);
            vec_low_i <= i[0];
            @(posedge clk_i);
            #1;
            chk(vec_addr_o, vtab[i / 2] + 16'(i[0]));
        end
        $display("vector test done");
    endtask

    task automatic nv_guard();
        @(posedge clk_i);
        addr_i    <= 16'hffbd;
        wr_i      <= 1'b1;
        flash_alt <= 1'b1;
        #1;
        chk(nv_wr_blocked_o, 1'b1);
        @(posedge clk_i);
        flash_prog_i <= 1'b1;
        #1;
        chk(nv_wr_blocked_o, 1'b0);
        @(posedge clk_i);
        flash_prog_i <= 1'b0;
        addr_i       <= 16'h0010;
        #1;
        chk(nv_wr_blocked_o, 1'b0);
        @(posedge clk_i);
        wr_i <= 1'b0;
        #1;
        chk({nv_protection_byte_o, nv_option_byte_o}, {PROT, OPT});
        $display("nonvolatile test done");
    endtask

    // reset in mid-run during stop3; flash now holds the altered bytes
    task automatic reload();
        @(posedge clk_i);
        debug_entry_enable_i <= 1'b1;
        stop_req_i           <= 1'b1;
        @(posedge clk_i);
        stop_req_i <= 1'b0;
        #1;
        chk(mode_stop3_o, 1'b1);
        @(posedge clk_i);
        nrst_i <= 1'b0;
        #1;
        chk({mode_stop3_o, periph_clk_en_o, nv_option_byte_o}, {2'b01, 8'h00});
        repeat (2) @(posedge clk_i);
        nrst_i <= 1'b1;
        @(posedge clk_i);
        #1;
        chk({nv_protection_byte_o, nv_option_byte_o}, {~PROT, ~OPT});
        $display("reset test done");
    endtask

    initial
    begin
        {stop_req_i, wake_i, debug_entry_enable_i, lowvolt_stop_enable_i, lvd_enable_i} = '0;
        {adc_async_clk_i, analog_comparator_bandgap_i, int_ref_clk_enable_i, int_ref_stop_enable_i} = '0;
        {ext_ref_clk_enable_i, ext_ref_stop_enable_i, osc_high_range_i, rtc_enable_i} = '0;
        {direct_i, wr_i, vec_low_i, flash_prog_i, flash_alt, bit_op_i, vec_sel_i} = '0;
        {addr_i, bit_mask_i} = '0;
        nrst_i = 1'b0;
        @(posedge clk_i);
        #1;
        chk(periph_clk_en_o, 1'b1);
        chk(vec_addr_o, 16'hfffe);
        repeat (2) @(posedge clk_i);
        nrst_i <= 1'b1;
        @(posedge clk_i);
        #1;
        chk({nv_protection_byte_o, nv_option_byte_o}, {PROT, OPT});
        for (int i = 0; i < 6; i++)
            stop_case(ctab[i]);
        decode();
        bit_ops();
        vectors();
        nv_guard();
        reload();
        end_of_test();
    end
endmodule
